// file: common/ddr_seq_pkg.sv
package ddr_seq_pkg;

	// system clock and the memory clock made from it by a divider
	localparam int CLK_PERIOD_NS = 100;
	localparam int CK_DIV        = 2;
	localparam int CK_PERIOD_NS  = CLK_PERIOD_NS * CK_DIV;

	// device timing, figures as printed
	localparam int  T_PWRUP_US = 200;
	localparam int  T_RP_NS    = 15;
	localparam int  T_RFC_NS   = 70;
	localparam int  T_RAS_NS   = 40;
	localparam real T_REFI_US  = 7.8;
	localparam real T_REFC_US  = 70.3;
	localparam int  DLL_LOCK_CK = 200;
	localparam int  T_MRD_CK    = 2;
	localparam int  MAX_POSTPONE = 8;

	// least times round up, longest times round down, never below one
	localparam int PWRUP_CK = (T_PWRUP_US * 1000 + CK_PERIOD_NS - 1)
		/ CK_PERIOD_NS;
	localparam int RP_RAW  = (T_RP_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS;
	localparam int RFC_RAW = (T_RFC_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS;
	localparam int RAS_RAW = (T_RAS_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS;
	localparam int RP_CK   = (RP_RAW < 1) ? 1 : RP_RAW;
	localparam int RFC_CK  = (RFC_RAW < 1) ? 1 : RFC_RAW;
	localparam int RAS_CK  = (RAS_RAW < 1) ? 1 : RAS_RAW;
	localparam int REFI_CK = int'($floor(T_REFI_US * 1000.0
		/ real'(CK_PERIOD_NS)));
	localparam int REFC_CK = int'($floor(T_REFC_US * 1000.0
		/ real'(CK_PERIOD_NS)));

	// counter widths
	localparam int TMR_W  = 11;
	localparam int REFI_W = 7;
	localparam int DLL_W  = 8;
	localparam int RAS_W  = 4;
	localparam int PEND_W = 4;

	// command pins {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_NOP   = 4'h7;
	localparam logic [3:0] CMD_DESEL = 4'hf;
	localparam logic [3:0] CMD_ACT   = 4'h3;
	localparam logic [3:0] CMD_READ  = 4'h5;
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_PRE   = 4'h2;
	localparam logic [3:0] CMD_AREF  = 4'h1;
	localparam logic [3:0] CMD_LMR   = 4'h0;

	// mode register fields
	localparam int         AP_BIT             = 10;
	localparam int         DLL_RESET_BIT      = 8;
	localparam int         DLL_DISABLE_BIT    = 0;
	localparam int         DRIVE_STRENGTH_BIT = 1;
	localparam logic [1:0] BA_MODE            = 2'h0;
	localparam logic [1:0] BA_EXT_MODE        = 2'h1;

	// software register map (word index)
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_MODE   = 4'h1;
	localparam logic [3:0] REG_CMD    = 4'h2;
	localparam logic [3:0] REG_STATUS = 4'h3;

	// fields of the control register
	localparam int CTRL_START   = 0;
	localparam int CTRL_DRIVE   = 1;
	localparam int CTRL_MRCLEAR = 2;
	localparam int CTRL_DLLRST  = 3;

	// user command kinds in the command register, bits [2:0]
	localparam logic [2:0] KIND_ACT   = 3'h0;
	localparam logic [2:0] KIND_READ  = 3'h1;
	localparam logic [2:0] KIND_WRITE = 3'h2;
	localparam logic [2:0] KIND_PRE   = 3'h3;

	localparam logic [12:0] MODE_RESET = 13'h0032;

	typedef enum logic [3:0] {
		S_PWRUP = 4'h0,
		S_NOP1  = 4'h1,
		S_PRE1  = 4'h3,
		S_EMR   = 4'h2,
		S_MR    = 4'h6,
		S_PRE2  = 4'h7,
		S_REF1  = 4'h5,
		S_REF2  = 4'h4,
		S_MR2   = 4'hc,
		S_IDLE  = 4'hd
	} seq_state_t;

endpackage

// file: design/slot_timer.sv
`timescale 1ns/1ps
module slot_timer
	import ddr_seq_pkg::*;
#(
	parameter int W = TMR_W
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// control
	input  wire logic         tick,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	// status
	output logic              done
);

	typedef struct packed {
		logic [W-1:0] cnt;
	} tmr_state_t;

	tmr_state_t s_q;
	tmr_state_t s_d;

	generate
		if (W < 2) begin : g_chk
			$error("slot_timer width too small");
		end
	endgenerate

	// load wins over the count so a wait restarts cleanly
	always_comb begin
		s_d = s_q;
		if (load) begin
			s_d.cnt = load_val;
		end else if (tick && s_q.cnt != '0) begin
			s_d.cnt = s_q.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign done = (s_q.cnt == '0);

endmodule

// file: design/ddr_init_refresh_sequencer.sv
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
// Function
// - refresh at least every 70.3 us; never postpone more than eight.
// - CKE stays high from each auto refresh until its period ends.
// - auto-precharge read or write only once active-to-precharge is met.
// - after a clock change reset the DLL, wait 200 cycles before reads.
// - hold CKE low with clock running for at least 200 us.
// - raise CKE, then give at least one NOP before anything else.
// - precharge all, then only NOPs for the precharge period.
// - load extended mode: DLL enabled, drive bit chosen, upper bits zero.
// - only NOPs for the mode-register delay after every mode load.
// - load base mode with DLL reset; 200 cycles before any read.
// - second precharge all, then NOPs for the precharge period.
// - two auto refreshes, each followed by NOPs for refresh cycle time.
// - optional base mode reload with DLL reset cleared, then wait.
// - at least 15 ns from precharge to the next command.
// - at least 70 ns from auto refresh to next non-NOP command.
// - spread refreshes evenly so every row sees one each 64 ms.
module ddr_init_refresh_sequencer
	import ddr_seq_pkg::*;
#(
	parameter int PWRUP_CYC = PWRUP_CK,
	parameter int RP_CYC    = RP_CK,
	parameter int RFC_CYC   = RFC_CK,
	parameter int MRD_CYC   = T_MRD_CK,
	parameter int RAS_CYC   = RAS_CK,
	parameter int REFI_CYC  = REFI_CK,
	parameter int DLL_CYC   = DLL_LOCK_CK
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// software register port
	input  wire logic [3:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [31:0]      rdata,
	// memory clock and command pins
	output logic             ck,
	output logic             ck_n,
	output logic             cke,
	output logic             cs_n,
	output logic             ras_n,
	output logic             cas_n,
	output logic             we_n,
	output logic [1:0]       ba,
	output logic [12:0]      mem_addr
);

	// refuse zero waits, postponement past the longest gap, and counts the power-up, RAS, interval and DLL counters cannot hold
	generate
		if (PWRUP_CYC < 1 || PWRUP_CYC >= (1 << TMR_W)) begin : g_pw
			$error("power-up count out of range");
		end
		if (RP_CYC < 1 || RFC_CYC < 1 || MRD_CYC < 1) begin : g_w
			$error("wait counts must be at least one");
		end
		if (RAS_CYC < 1 || RAS_CYC >= (1 << RAS_W)) begin : g_ras
			$error("active-to-precharge count out of range");
		end
		if (REFI_CYC < 2 || REFI_CYC >= (1 << REFI_W)) begin : g_refi
			$error("refresh interval out of range");
		end
		if (REFI_CYC * (MAX_POSTPONE + 1) > REFC_CK) begin : g_refc
			$error("postponed refreshes would exceed the longest gap");
		end
		if (DLL_CYC < 1 || DLL_CYC >= (1 << DLL_W)) begin : g_dll
			$error("DLL lock count out of range");
		end
	endgenerate

	localparam logic [TMR_W-1:0]  PWRUP_LD = TMR_W'(PWRUP_CYC - 1);
	localparam logic [TMR_W-1:0]  RP_LD    = TMR_W'(RP_CYC - 1);
	localparam logic [TMR_W-1:0]  RFC_LD   = TMR_W'(RFC_CYC - 1);
	localparam logic [TMR_W-1:0]  MRD_LD   = TMR_W'(MRD_CYC - 1);
	localparam logic [REFI_W-1:0] REFI_TOP = REFI_W'(REFI_CYC - 1);
	localparam logic [DLL_W-1:0]  DLL_TOP  = DLL_W'(DLL_CYC);
	localparam logic [RAS_W-1:0]  RAS_TOP  = RAS_W'(RAS_CYC);
	localparam logic [PEND_W-1:0] PEND_MAX = PEND_W'(MAX_POSTPONE);

	typedef struct packed {
		seq_state_t        st;
		logic              ck;
		logic              ck_n;
		logic              cke;
		logic [3:0]        cmd;
		logic [1:0]        ba;
		logic [12:0]       ma;
		logic              go;
		logic              drive;
		logic              mr_clear;
		logic              dll_req;
		logic [12:0]       mode;
		logic              req;
		logic [2:0]        req_kind;
		logic [1:0]        req_ba;
		logic [12:0]       req_ma;
		logic [REFI_W-1:0] refi;
		logic [PEND_W-1:0] pend;
		logic [DLL_W-1:0]  dll;
		logic [RAS_W-1:0]  ras;
		logic              done;
		logic [31:0]       rdata;
	} seq_regs_t;

	seq_regs_t        s_q;
	seq_regs_t        s_d;
	logic             slot;
	logic             t_done;
	logic             t_load;
	logic [TMR_W-1:0] t_val;
	logic             read_ok;
	logic             ap_ok;
	logic             req_ok;

	slot_timer #(
		.W        (TMR_W)
	) u_wait (
		.clk      (clk),
		.rst      (rst),
		.tick     (slot),
		.load     (t_load),
		.load_val (t_val),
		.done     (t_done)
	);

	// commands change as ck falls, between the edges that sample them
	assign slot    = s_q.ck;
	assign read_ok = (s_q.dll == DLL_TOP);
	assign ap_ok   = (s_q.ras >= RAS_TOP);
	assign req_ok  = !(s_q.req_kind == KIND_READ && !read_ok)
		&& !((s_q.req_kind == KIND_READ || s_q.req_kind == KIND_WRITE)
		&& s_q.req_ma[AP_BIT] && !ap_ok);

	always_comb begin
		s_d        = s_q;
		t_load     = 1'b0;
		t_val      = '0;
		s_d.ck     = ~s_q.ck;
		s_d.ck_n   = s_q.ck;
		s_d.rdata  = '0;

		if (slot) begin
			// every slot without a command of its own is a NOP
			s_d.cmd = CMD_NOP;
			if (s_q.dll != DLL_TOP) begin
				s_d.dll = s_q.dll + 1'b1;
			end
			if (s_q.ras != RAS_TOP) begin
				s_d.ras = s_q.ras + 1'b1;
			end
			// the interval counter runs once the device is ready
			if (s_q.done) begin
				if (s_q.refi == REFI_TOP) begin
					s_d.refi = '0;
					// count past the limit, holding at all ones rather than wrapping
					if (s_q.pend != '1) begin
						s_d.pend = s_q.pend + 1'b1;
					end
				end else begin
					s_d.refi = s_q.refi + 1'b1;
				end
			end

			unique case (s_q.st)
				S_PWRUP: begin
					s_d.cke = 1'b0;
					if (!s_q.go) begin
						// the wait only starts once software says go
						t_load = 1'b1;
						t_val  = PWRUP_LD;
					end else if (t_done) begin
						s_d.cke = 1'b1;
						s_d.st  = S_NOP1;
					end
				end
				S_NOP1: s_d.st = S_PRE1;
				S_PRE1: begin
					if (t_done) begin
						s_d.cmd        = CMD_PRE;
						s_d.ma         = '0;
						s_d.ma[AP_BIT] = 1'b1;
						t_load         = 1'b1;
						t_val          = RP_LD;
						s_d.st         = S_EMR;
					end
				end
				S_EMR: begin
					if (t_done) begin
						s_d.cmd = CMD_LMR;
						s_d.ba  = BA_EXT_MODE;
						s_d.ma  = '0;
						s_d.ma[DLL_DISABLE_BIT]    = 1'b0;
						s_d.ma[DRIVE_STRENGTH_BIT] = s_q.drive;
						t_load  = 1'b1;
						t_val   = MRD_LD;
						s_d.st  = S_MR;
					end
				end
				S_MR: begin
					if (t_done) begin
						s_d.cmd = CMD_LMR;
						s_d.ba  = BA_MODE;
						s_d.ma  = s_q.mode;
						s_d.ma[DLL_RESET_BIT] = 1'b1;
						s_d.dll = '0;
						t_load  = 1'b1;
						t_val   = MRD_LD;
						s_d.st  = S_PRE2;
					end
				end
				S_PRE2: begin
					if (t_done) begin
						s_d.cmd        = CMD_PRE;
						s_d.ba         = '0;
						s_d.ma         = '0;
						s_d.ma[AP_BIT] = 1'b1;
						t_load         = 1'b1;
						t_val          = RP_LD;
						s_d.st         = S_REF1;
					end
				end
				S_REF1: begin
					if (t_done) begin
						s_d.cmd = CMD_AREF;
						t_load  = 1'b1;
						t_val   = RFC_LD;
						s_d.st  = S_REF2;
					end
				end
				S_REF2: begin
					if (t_done) begin
						s_d.cmd = CMD_AREF;
						t_load  = 1'b1;
						t_val   = RFC_LD;
						if (s_q.mr_clear) begin
							s_d.st = S_MR2;
						end else begin
							s_d.st   = S_IDLE;
							s_d.done = 1'b1;
						end
					end
				end
				S_MR2: begin
					if (t_done) begin
						s_d.cmd  = CMD_LMR;
						s_d.ba   = BA_MODE;
						s_d.ma   = s_q.mode;
						s_d.ma[DLL_RESET_BIT] = 1'b0;
						t_load   = 1'b1;
						t_val    = MRD_LD;
						s_d.st   = S_IDLE;
						s_d.done = 1'b1;
					end
				end
				S_IDLE: begin
					// the shared timer also spaces precharge and refresh
					if (t_done) begin
						if (s_q.pend >= PEND_MAX
							|| (s_q.pend != '0 && !s_q.req)) begin
							// user work may hold refresh off up to the limit
							s_d.cmd  = CMD_AREF;
							s_d.pend = s_d.pend - 1'b1;
							t_load   = 1'b1;
							t_val    = RFC_LD;
						end else if (s_q.dll_req) begin
							s_d.cmd     = CMD_LMR;
							s_d.ba      = BA_MODE;
							s_d.ma      = s_q.mode;
							s_d.ma[DLL_RESET_BIT] = 1'b1;
							s_d.dll     = '0;
							s_d.dll_req = 1'b0;
							t_load      = 1'b1;
							t_val       = MRD_LD;
						end else if (s_q.req && req_ok) begin
							s_d.req = 1'b0;
							s_d.ba  = s_q.req_ba;
							s_d.ma  = s_q.req_ma;
							unique case (s_q.req_kind)
								KIND_ACT: begin
									s_d.cmd = CMD_ACT;
									s_d.ras = '0;
								end
								KIND_READ: s_d.cmd = CMD_READ;
								KIND_WRITE: s_d.cmd = CMD_WRITE;
								default: begin
									s_d.cmd = CMD_PRE;
									t_load  = 1'b1;
									t_val   = RP_LD;
								end
							endcase
						end
					end
				end
				default: begin
					s_d.st  = S_PWRUP;
					s_d.cke = 1'b0;
				end
			endcase
		end

		// CKE never drops once raised, so it spans every refresh
		if (s_q.st != S_PWRUP) begin
			s_d.cke = 1'b1;
		end

		// register writes come last so a DLL reset write beats a same-cycle clear
		if (wr) begin
			unique case (addr)
				REG_CTRL: begin
					s_d.go       = wdata[CTRL_START];
					s_d.drive    = wdata[CTRL_DRIVE];
					s_d.mr_clear = wdata[CTRL_MRCLEAR];
					s_d.dll_req  = s_d.dll_req | wdata[CTRL_DLLRST];
				end
				REG_MODE: s_d.mode = wdata[12:0];
				REG_CMD: begin
					if (!s_q.req && s_q.done) begin
						s_d.req      = 1'b1;
						s_d.req_kind = wdata[2:0];
						s_d.req_ba   = wdata[4:3];
						s_d.req_ma   = wdata[17:5];
					end
				end
				default: ;
			endcase
		end

		if (rd) begin
			unique case (addr)
				REG_CTRL: s_d.rdata = {28'h0000000, s_q.dll_req,
					s_q.mr_clear, s_q.drive, s_q.go};
				REG_MODE: s_d.rdata = {19'h00000, s_q.mode};
				REG_CMD: s_d.rdata = {14'h0000, s_q.req_ma, s_q.req_ba,
					s_q.req_kind};
				REG_STATUS: s_d.rdata = {20'h00000, s_q.st, s_q.pend,
					1'b0, s_q.req, read_ok, s_q.done};
				default: s_d.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q       <= '0;
			s_q.st    <= S_PWRUP;
			s_q.ck_n  <= 1'b1;
			s_q.cmd   <= CMD_NOP;
			s_q.mode  <= MODE_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata    = s_q.rdata;
	assign ck       = s_q.ck;
	assign ck_n     = s_q.ck_n;
	assign cke      = s_q.cke;
	assign {cs_n, ras_n, cas_n, we_n} = s_q.cmd;
	assign ba       = s_q.ba;
	assign mem_addr = s_q.ma;

endmodule

// file: bench/ddr_seq_props.sv
`timescale 1ns/1ps
module ddr_seq_props
	import ddr_seq_pkg::*;
#(
	parameter int PWRUP_CYC = PWRUP_CK,
	parameter int RP_CYC    = RP_CK,
	parameter int RFC_CYC   = RFC_CK,
	parameter int MRD_CYC   = T_MRD_CK,
	parameter int DLL_CYC   = DLL_LOCK_CK
) (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// memory side
	input wire logic        ck,
	input wire logic        ck_n,
	input wire logic        cke,
	input wire logic        cs_n,
	input wire logic        ras_n,
	input wire logic        cas_n,
	input wire logic        we_n,
	input wire logic [1:0]  ba,
	input wire logic [12:0] mem_addr
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	logic [3:0]  cmd;
	logic        idle;
	logic        start;
	logic [3:0]  last_q;
	logic [15:0] gap_q;
	logic [15:0] dll_q;
	logic [15:0] low_q;
	logic [15:0] ref_q;
	logic        dll_seen_q;
	logic        ref_seen_q;

	function automatic logic [15:0] sat(input logic [15:0] x);
		return (x == 16'hffff) ? x : x + 16'h1;
	endfunction

	assign cmd = {cs_n, ras_n, cas_n, we_n};
	assign idle = cs_n | (cmd == CMD_NOP);
	// a slot begins where ck has just fallen, so one start per command
	assign start = !ck & !idle;

	always_ff @(posedge clk) begin
		if (rst) begin
			last_q <= CMD_NOP;
			gap_q <= 16'h0;
			dll_q <= 16'h0;
			low_q <= 16'h0;
			ref_q <= 16'h0;
			dll_seen_q <= 1'h0;
			ref_seen_q <= 1'h0;
		end else begin
			last_q <= start ? cmd : last_q;
			gap_q <= start ? 16'h1 : sat(gap_q);
			low_q <= cke ? low_q : sat(low_q);
			if (start && cmd == CMD_LMR && ba == BA_MODE
				&& mem_addr[DLL_RESET_BIT]) begin
				dll_q <= 16'h1;
				dll_seen_q <= 1'h1;
			end else begin
				dll_q <= sat(dll_q);
			end
			if (start && cmd == CMD_AREF) begin
				ref_q <= 16'h1;
				ref_seen_q <= 1'h1;
			end else begin
				ref_q <= sat(ref_q);
			end
		end
	end

	sequence s_pad;
		idle [*4] ##1 (cmd == CMD_PRE && mem_addr[AP_BIT]);
	endsequence

	chk_ck_toggle: assert property (
		!$past(rst) |-> (ck != $past(ck)) && (ck_n == !ck))
		else $error("memory clock not toggling");
	chk_cke_hold: assert property (cke |=> cke)
		else $error("clock enable dropped");
	chk_powerup_pad: assert property ($rose(cke) |-> s_pad)
		else $error("no nop padding then precharge all");
	chk_rp_gap: assert property (
		start && last_q == CMD_PRE |-> int'(gap_q) >= 2 * RP_CYC)
		else $error("command too soon after precharge");
	chk_rfc_gap: assert property (
		start && last_q == CMD_AREF |-> int'(gap_q) >= 2 * RFC_CYC)
		else $error("command too soon after refresh");
	chk_mrd_gap: assert property (
		start && last_q == CMD_LMR |-> int'(gap_q) >= 2 * MRD_CYC)
		else $error("command too soon after mode load");
	chk_emr_value: assert property (
		start && cmd == CMD_LMR && ba == BA_EXT_MODE
		|-> !mem_addr[DLL_DISABLE_BIT] && mem_addr[12:2] == 11'h0)
		else $error("bad extended mode value");
	chk_dll_read: assert property (
		start && cmd == CMD_READ
		|-> dll_seen_q && int'(dll_q) >= 2 * DLL_CYC)
		else $error("read too soon after dll reset");
	chk_cke_low_wait: assert property (
		$rose(cke) |-> int'(low_q) >= 2 * PWRUP_CYC)
		else $error("power-up wait too short");
	chk_cke_low_idle: assert property (!cke |-> idle)
		else $error("command while clock enable low");
	chk_refresh_span: assert property (
		ref_seen_q |-> int'(ref_q) <= 2 * REFC_CK)
		else $error("refresh interval too long");
endmodule

bind ddr_init_refresh_sequencer ddr_seq_props #(
	.PWRUP_CYC(PWRUP_CYC),
	.RP_CYC(RP_CYC),
	.RFC_CYC(RFC_CYC),
	.MRD_CYC(MRD_CYC),
	.DLL_CYC(DLL_CYC)
) ddr_seq_props_i (.clk(clk), .rst(rst), .ck(ck), .ck_n(ck_n),
	.cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
	.ba(ba), .mem_addr(mem_addr));

// file: bench/ddr_dram_model.sv
`timescale 1ns/1ps
module ddr_dram_model
	import ddr_seq_pkg::*;
(
	// memory clock
	input wire logic        ck,
	input wire logic        ck_n,
	input wire logic        cke,
	// command and address
	input wire logic        cs_n,
	input wire logic        ras_n,
	input wire logic        cas_n,
	input wire logic        we_n,
	input wire logic [1:0]  ba,
	input wire logic [12:0] mem_addr
);
	logic [3:0]  cmd;
	logic [3:0]  log_cmd [0:15];
	logic [12:0] log_addr [0:15];
	logic [1:0]  log_ba [0:15];
	logic [12:0] last_lmr = 13'h0;
	logic        ready = 1'h0;
	logic        bad = 1'h0;
	int          n_log = 0;
	int          low_ck = 0;
	int          n_aref = 0;
	int          n_read = 0;
	int          n_write = 0;
	int          since_act = 0;
	int          ap_gap = 0;

	// command pins only: byte lanes and their strobes stay out
	assign cmd = {cs_n, ras_n, cas_n, we_n};

	always @(posedge ck) begin
		since_act++;
		if (ck_n !== 1'h0)
			bad = 1'h1;
		if (cke !== 1'h1) begin
			low_ck++;
			if (!cs_n && cmd !== CMD_NOP)
				bad = 1'h1;
		end else if (!cs_n && cmd !== CMD_NOP) begin
			if (n_log < 16) begin
				log_cmd[n_log] = cmd;
				log_addr[n_log] = mem_addr;
				log_ba[n_log] = ba;
			end
			n_log++;
			// row activates and reads only once initialized
			if (!ready && (cmd == CMD_ACT || cmd == CMD_READ))
				bad = 1'h1;
			if (cmd == CMD_AREF)
				n_aref++;
			if (n_aref >= 2)
				ready = 1'h1;
			if (cmd == CMD_ACT)
				since_act = 0;
			if (cmd == CMD_READ)
				n_read++;
			if (cmd == CMD_WRITE)
				n_write++;
			if ((cmd == CMD_READ || cmd == CMD_WRITE) && mem_addr[AP_BIT])
				ap_gap = since_act;
			if (cmd == CMD_LMR && ba == BA_MODE)
				last_lmr = mem_addr;
		end
	end
endmodule

// file: bench/tb_ddr_init_refresh_sequencer.sv
`timescale 1ns/1ps
module tb_ddr_init_refresh_sequencer
	import ddr_seq_pkg::*;
;
	localparam int PW = 6;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic        wr = 1'h0;
	logic        rd = 1'h0;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] v;
	logic        ck, ck_n, cke, cs_n, ras_n, cas_n, we_n;
	logic [1:0]  ba;
	logic [12:0] mem_addr;
	int          n_errors = 0;
	int          check_count = 0;
	int          a0;
	logic [3:0]  ec [0:6] = '{CMD_PRE, CMD_LMR, CMD_LMR, CMD_PRE,
		CMD_AREF, CMD_AREF, CMD_LMR};
	logic [12:0] mk [0:6] = '{13'h0400, 13'h1fff, 13'h1fff, 13'h0400,
		13'h0, 13'h0, 13'h1fff};
	logic [12:0] ea [0:6] = '{13'h0400, 13'h0002, 13'h0163, 13'h0400,
		13'h0, 13'h0, 13'h0063};

	always #50 clk = ~clk;

	ddr_init_refresh_sequencer #(.PWRUP_CYC(PW)) ddr_init_refresh_sequencer_i (
		.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .ck(ck), .ck_n(ck_n), .cke(cke),
		.cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.ba(ba), .mem_addr(mem_addr));
	ddr_dram_model ddr_dram_model_i (.ck(ck), .ck_n(ck_n), .cke(cke),
		.cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.ba(ba), .mem_addr(mem_addr));

	task automatic complete_run;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			$display("Error at %0t: got %h expected %h", $time, g, e);
			n_errors++;
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask

	task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1;
		d = rdata;
	endtask

	// bounded wait on one status bit; a timeout shows as a mismatch
	task automatic poll(input int b, input logic e, input int lim);
		for (int k = 0; k < lim; k++) begin
			rd_reg(REG_STATUS, v);
			if (v[b] === e)
				break;
		end
		chk(v[b], e);
	endtask

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		rd_reg(REG_MODE, v);
		chk(v, 32'h32);
		wr_reg(REG_MODE, 32'h63);
		wr_reg(REG_CTRL, 32'h7);
		poll(0, 1'h1, 200);
		chk(v[11:8], S_IDLE);
		chk(ddr_dram_model_i.n_log, 7);
		for (int k = 0; k < 7; k++) begin
			chk(ddr_dram_model_i.log_cmd[k], ec[k]);
			chk(ddr_dram_model_i.log_addr[k] & mk[k], ea[k]);
		end
		chk(ddr_dram_model_i.log_ba[1], BA_EXT_MODE);
		chk(ddr_dram_model_i.log_ba[2], BA_MODE);
		chk(ddr_dram_model_i.low_ck >= PW, 1);
		rd_reg(4'h9, v);
		chk(v, 32'h0);
		@(posedge clk);
		#1;
		chk(rdata, 32'h0);
		// a read with auto precharge right after init must wait
		wr_reg(REG_CMD, 32'ha8);
		poll(2, 1'h0, 50);
		wr_reg(REG_CMD, 32'h8009);
		rd_reg(REG_STATUS, v);
		chk(v[2:1], 2'h2);
		chk(ddr_dram_model_i.n_read, 0);
		poll(1, 1'h1, 400);
		poll(2, 1'h0, 50);
		chk(ddr_dram_model_i.n_read, 1);
		chk(ddr_dram_model_i.ap_gap >= RAS_CK, 1);
		// reopen the row, write to it, then close all banks
		wr_reg(REG_CMD, 32'ha8);
		poll(2, 1'h0, 50);
		wr_reg(REG_CMD, 32'h0a);
		poll(2, 1'h0, 50);
		wr_reg(REG_CMD, 32'h8003);
		poll(2, 1'h0, 50);
		rd_reg(REG_CMD, v);
		chk(v, 32'h8003);
		chk(ddr_dram_model_i.n_write, 1);
		// a fresh dll reset withdraws read permission
		wr_reg(REG_CTRL, 32'hf);
		poll(1, 1'h0, 50);
		chk(ddr_dram_model_i.last_lmr, 13'h0163);
		a0 = ddr_dram_model_i.n_aref;
		repeat (780) @(posedge clk);
		a0 = ddr_dram_model_i.n_aref - a0;
		chk(a0 >= 9 && a0 <= 11, 1);
		chk(cke, 1'h1);
		chk(ddr_dram_model_i.bad, 1'h0);
		complete_run;
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		complete_run;
	end
endmodule
